// *** rtl/cpm_defs.vh ***
// constants for the programming-model register block
`ifndef CPM_DEFS_VH
`define CPM_DEFS_VH
// system control unit register numbers
`define CPM_REG_CACHE_CFG 5'h03
`define CPM_REG_FAULT_ADDR 5'h08
`define CPM_REG_PROC_STATE 5'h0C
`define CPM_REG_EXC_REASON 5'h0D
`define CPM_REG_EXC_PC 5'h0E
`define CPM_REG_REVISION 5'h0F
// general register numbers
`define CPM_GPR_ZERO 5'h00
`define CPM_GPR_LINK 5'h1F
// processor_state fields
`define CPM_PS_KU_CUR 1
`define CPM_PS_KU_PREV 3
`define CPM_PS_CU0 28
// exception reason codes, bits 6:2 of exception_reason
`define CPM_EXC_ADDR_LOAD 5'h04
`define CPM_EXC_ADDR_STORE 5'h05
`define CPM_EXC_COP_UNUSABLE 5'h0B
// reset values
`define CPM_RST_CACHE_CFG 32'h00000000
`define CPM_RST_PROC_STATE 32'h00000000
// access sizes
`define CPM_SZ_BYTE 3'h0
`define CPM_SZ_HALF 3'h1
`define CPM_SZ_WORD 3'h2
`define CPM_SZ_LEFT 3'h3
`define CPM_SZ_RIGHT 3'h4
`endif

// *** rtl/cpm_programming_model.v ***
// programming-model state: general registers, result pair, system control unit, modes
`timescale 1ns/1ps
`include "cpm_defs.vh"
module cpm_programming_model #(
  parameter REVISION_ID = 32'h00000A5A // arbitrary value
) (
  input wire clk_i,
  input wire rst_i,
  input wire big_endian_i,
  // general register ports
  input wire [4:0] rd_a_sel_i,
  input wire [4:0] rd_b_sel_i,
  output reg [31:0] rd_a_data_o,
  output reg [31:0] rd_b_data_o,
  input wire gpr_wr_i,
  input wire [4:0] gpr_wr_sel_i,
  input wire [31:0] gpr_wr_data_i,
  input wire link_wr_i,
  input wire [31:0] link_addr_i,
  // result pair
  input wire mul_done_i,
  input wire div_done_i,
  input wire [63:0] mdu_result_i,
  input wire hi_wr_i,
  input wire lo_wr_i,
  input wire [31:0] hilo_wr_data_i,
  output reg [31:0] result_high_o,
  output reg [31:0] result_low_o,
  // load/store lane steering
  input wire mem_req_i,
  input wire mem_store_i,
  input wire [2:0] mem_size_i,
  input wire [31:0] mem_addr_i,
  output reg [3:0] lane_en_o,
  output reg mem_ok_o,
  // system control unit access
  input wire scu_rd_i,
  input wire scu_wr_i,
  input wire [4:0] scu_sel_i,
  input wire [31:0] scu_wr_data_i,
  output reg [31:0] scu_rd_data_o,
  // exceptions
  input wire exc_i,
  input wire [4:0] exc_code_i,
  input wire [31:0] exc_pc_i,
  input wire exc_return_instr_i,
  output reg kernel_mode_o,
  output reg big_endian_o,
  output reg exc_raise_o,
  output reg [4:0] exc_raise_code_o
);
  // ****************************************
  // helpers
  // ****************************************
  // lane of byte offset b; lane 0 is bits 7:0
  function [1:0] lane_of;
    input [1:0] b;
    input be;
    begin
      lane_of = be ? ~b : b;
    end
  endfunction

  function [3:0] lanes;
    input [2:0] sz;
    input [1:0] a;
    input be;
    reg [3:0] m;
    integer i;
    begin
      m = 4'h0;
      case (sz)
        `CPM_SZ_BYTE: m[lane_of(a, be)] = 1'b1;
        `CPM_SZ_HALF: begin
          m[lane_of(a, be)] = 1'b1;
          m[lane_of(a | 2'h1, be)] = 1'b1;
        end
        `CPM_SZ_WORD: m = 4'hF;
        `CPM_SZ_LEFT: begin
          // from the addressed byte to the end of the word
          for (i = 0; i < 4; i = i + 1) begin
            if (i[1:0] >= a) m[lane_of(i[1:0], be)] = 1'b1;
          end
        end
        `CPM_SZ_RIGHT: begin
          for (i = 0; i < 4; i = i + 1) begin
            if (i[1:0] <= a) m[lane_of(i[1:0], be)] = 1'b1;
          end
        end
        default: m = 4'h0;
      endcase
      lanes = m;
    end
  endfunction

  // half words need even addresses, words multiples of four
  function misaligned;
    input [2:0] sz;
    input [1:0] a;
    begin
      misaligned = (sz == `CPM_SZ_HALF && a[0]) ||
        (sz == `CPM_SZ_WORD && a != 2'h0);
    end
  endfunction

  function valid_sel;
    input [4:0] s;
    begin
      valid_sel = (s == `CPM_REG_CACHE_CFG) || (s == `CPM_REG_FAULT_ADDR) ||
        (s >= `CPM_REG_PROC_STATE && s <= `CPM_REG_REVISION);
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [31:0] gpr_r [0:31];
  reg [31:0] cache_cfg_r;
  reg [31:0] fault_addr_r;
  reg [31:0] proc_state_r;
  reg [31:0] exc_reason_r;
  reg [31:0] exc_pc_r;
  reg strap_done_r;
  integer k;
  reg be_meta_r;
  reg be_sync_r;
  reg [31:0] proc_state_nxt;
  reg kernel_nxt;

  // zero register reads as zero whatever its flops hold
  function [31:0] gpr_value;
    input [4:0] s;
    begin
      gpr_value = (s == `CPM_GPR_ZERO) ? 32'h00000000 : gpr_r[s];
    end
  endfunction

  // contents of a control register; reserved numbers read as zero
  function [31:0] scu_value;
    input [4:0] s;
    begin
      case (s)
        `CPM_REG_CACHE_CFG: scu_value = cache_cfg_r;
        `CPM_REG_FAULT_ADDR: scu_value = fault_addr_r;
        `CPM_REG_PROC_STATE: scu_value = proc_state_r;
        `CPM_REG_EXC_REASON: scu_value = exc_reason_r;
        `CPM_REG_EXC_PC: scu_value = exc_pc_r;
        `CPM_REG_REVISION: scu_value = REVISION_ID;
        default: scu_value = 32'h00000000;
      endcase
    end
  endfunction

  wire user_w = proc_state_r[`CPM_PS_KU_CUR];
  wire [1:0] seg_w = mem_addr_i[31:30];
  // user may only reach the low half of the space
  wire seg_deny_w = user_w && seg_w[1];
  wire mis_w = misaligned(mem_size_i, mem_addr_i[1:0]);
  wire mem_bad_w = mem_req_i && (seg_deny_w || mis_w);
  wire scu_deny_w = (scu_rd_i || scu_wr_i) && user_w &&
    !proc_state_r[`CPM_PS_CU0];
  wire sw_wr_w = scu_wr_i && !scu_deny_w && valid_sel(scu_sel_i);
  wire take_exc_w = exc_i || mem_bad_w || scu_deny_w;
  wire [4:0] code_w = exc_i ? exc_code_i :
    mem_bad_w ? (mem_store_i ? `CPM_EXC_ADDR_STORE : `CPM_EXC_ADDR_LOAD) :
    `CPM_EXC_COP_UNUSABLE;

  // ****************************************
  // byte order strap
  // ****************************************
  // the strap pin is not timed to clk_i; only the second stage is read
  always @(posedge clk_i) begin
    be_meta_r <= big_endian_i;
    be_sync_r <= be_meta_r;
  end

  // a strap change after release is ignored until the next reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_done_r <= 1'b0;
      big_endian_o <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      big_endian_o <= be_sync_r;
    end
  end

  // ****************************************
  // general registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (k = 0; k < 32; k = k + 1) gpr_r[k] <= 32'h00000000;
    end else begin
      if (gpr_wr_i && gpr_wr_sel_i != `CPM_GPR_ZERO) begin
        gpr_r[gpr_wr_sel_i] <= gpr_wr_data_i;
      end
      // the link write lands after an ordinary write to the same cycle
      if (link_wr_i) gpr_r[`CPM_GPR_LINK] <= link_addr_i;
    end
  end

  // ****************************************
  // general register read ports
  // ****************************************
  // registered reads with no bypass: a write shows on a read issued a cycle later
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_a_data_o <= 32'h00000000;
      rd_b_data_o <= 32'h00000000;
    end else begin
      rd_a_data_o <= gpr_value(rd_a_sel_i);
      rd_b_data_o <= gpr_value(rd_b_sel_i);
    end
  end

  // ****************************************
  // multiply and divide result pair
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_high_o <= 32'h00000000;
      result_low_o <= 32'h00000000;
    end else if (mul_done_i || div_done_i) begin
      // product high:low, or remainder:quotient as packed by the divider
      result_high_o <= mdu_result_i[63:32];
      result_low_o <= mdu_result_i[31:0];
    end else begin
      // a finishing operation takes precedence over a move-to write
      if (hi_wr_i) result_high_o <= hilo_wr_data_i;
      if (lo_wr_i) result_low_o <= hilo_wr_data_i;
    end
  end

  // ****************************************
  // memory access checks
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      lane_en_o <= 4'h0;
      mem_ok_o <= 1'b0;
    end else begin
      mem_ok_o <= mem_req_i && !mem_bad_w;
      lane_en_o <= (mem_req_i && !mem_bad_w) ?
        lanes(mem_size_i, mem_addr_i[1:0], big_endian_o) : 4'h0;
    end
  end

  // ****************************************
  // system control unit reads
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      scu_rd_data_o <= 32'h00000000;
    end else if (scu_rd_i && !scu_deny_w) begin
      scu_rd_data_o <= scu_value(scu_sel_i);
    end else begin
      // the read port shows zero whenever nothing was read
      scu_rd_data_o <= 32'h00000000;
    end
  end

  // ****************************************
  // software-writable control registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      cache_cfg_r <= `CPM_RST_CACHE_CFG;
    end else if (sw_wr_w && scu_sel_i == `CPM_REG_CACHE_CFG) begin
      cache_cfg_r <= scu_wr_data_i;
    end
  end

  // ****************************************
  // exception capture
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_addr_r <= 32'h00000000;
      exc_reason_r <= 32'h00000000;
      exc_pc_r <= 32'h00000000;
      exc_raise_o <= 1'b0;
      exc_raise_code_o <= 5'h00;
    end else begin
      exc_raise_o <= take_exc_w;
      exc_raise_code_o <= take_exc_w ? code_w : 5'h00;
      // only bits 9:8 of the reason are software's; the code field is hardware's
      if (sw_wr_w && scu_sel_i == `CPM_REG_EXC_REASON) begin
        exc_reason_r[9:8] <= scu_wr_data_i[9:8];
      end
      if (take_exc_w) begin
        exc_reason_r[6:2] <= code_w;
        exc_pc_r <= exc_pc_i;
        if (mem_bad_w) fault_addr_r <= mem_addr_i;
      end
    end
  end

  // ****************************************
  // processor state and operating mode
  // ****************************************
  // bit 1 current user, bit 3 previous, bit 5 older; an exception pushes the
  // stack by two and a return pops it, so only two nested levels survive
  always @* begin
    proc_state_nxt = proc_state_r;
    if (sw_wr_w && scu_sel_i == `CPM_REG_PROC_STATE) begin
      proc_state_nxt = scu_wr_data_i;
    end
    // an exception overrides bits 5:0 of a software write, and a return, in the same cycle
    if (take_exc_w) begin
      proc_state_nxt[5:0] = {proc_state_r[3:0], 2'b00};
    end else if (exc_return_instr_i) begin
      proc_state_nxt[3:0] = proc_state_r[5:2];
    end
    kernel_nxt = !proc_state_nxt[`CPM_PS_KU_CUR];
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      proc_state_r <= `CPM_RST_PROC_STATE;
      kernel_mode_o <= 1'b1;
    end else begin
      proc_state_r <= proc_state_nxt;
      kernel_mode_o <= kernel_nxt;
    end
  end
endmodule // cpm_programming_model

// *** bench/cpm_pm_monitor.sv ***
// port checker for the programming-model block
`timescale 1ns/1ps
module cpm_pm_monitor (
  input clk_i,
  input rst_i,
  input [4:0] rd_a_sel_i,
  input [31:0] rd_a_data_o,
  input mem_req_i,
  input [2:0] mem_size_i,
  input [31:0] mem_addr_i,
  input [3:0] lane_en_o,
  input mem_ok_o,
  input kernel_mode_o,
  input big_endian_o,
  input exc_i,
  input exc_raise_o,
  input mul_done_i,
  input div_done_i,
  input [63:0] mdu_result_i,
  input [31:0] result_high_o,
  input [31:0] result_low_o,
  input scu_rd_i,
  input [4:0] scu_sel_i,
  input [31:0] scu_rd_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // kernel, or user below the top half
  wire ok_seg = kernel_mode_o || !mem_addr_i[31];
  zero_reg_a: assert property (rd_a_sel_i == 5'h00 |=> rd_a_data_o == 32'h0)
    else $error("zero register read nonzero");
  word_ok_a: assert property (mem_req_i && mem_size_i == 3'h2 &&
    mem_addr_i[1:0] == 2'h0 && ok_seg |=> mem_ok_o && lane_en_o == 4'hF) else $error("word");
  misalign_a: assert property (mem_req_i && (mem_size_i == 3'h2 && mem_addr_i[1:0] != 2'h0 ||
    mem_size_i == 3'h1 && mem_addr_i[0]) |=> !mem_ok_o && lane_en_o == 4'h0 && exc_raise_o)
    else $error("misaligned access taken");
  byte_lane_a: assert property (mem_req_i && mem_size_i == 3'h0 && ok_seg |=>
    lane_en_o == (big_endian_o ? 4'h8 >> $past(mem_addr_i[1:0]) : 4'h1 << $past(mem_addr_i[1:0])))
    else $error("byte lane");
  user_seg_a: assert property (!kernel_mode_o && mem_req_i && mem_addr_i[31] |=>
    !mem_ok_o && lane_en_o == 4'h0 && kernel_mode_o) else $error("user segment");
  exc_kernel_a: assert property (exc_i |=> kernel_mode_o && exc_raise_o)
    else $error("exception without kernel");
  mul_pair_a: assert property (mul_done_i || div_done_i |=>
    {result_high_o, result_low_o} == $past(mdu_result_i)) else $error("product");
  resv_scu_a: assert property (scu_rd_i && scu_sel_i inside {[0:2], [4:7], [9:11],
    [16:31]} |=> scu_rd_data_o == 32'h0) else $error("reserved read");
  exc_c: cover property (exc_i);
  seg_c: cover property (!kernel_mode_o && mem_req_i && mem_addr_i[31]);
  mul_c: cover property (mul_done_i);
endmodule // cpm_pm_monitor
bind cpm_programming_model cpm_pm_monitor u_mon (.clk_i, .rst_i, .rd_a_sel_i, .rd_a_data_o,
  .mem_req_i, .mem_size_i, .mem_addr_i, .lane_en_o, .mem_ok_o, .kernel_mode_o, .big_endian_o,
  .exc_i, .exc_raise_o, .mul_done_i, .div_done_i, .mdu_result_i, .result_high_o, .result_low_o,
  .scu_rd_i,
  .scu_sel_i, .scu_rd_data_o);

// *** bench/cpm_mdu_model.sv ***
// multiply unit model on the pipeline side
`timescale 1ns/1ps
module cpm_mdu_model (
  input clk_i,
  input start_i,
  input [3:0] lat_i,
  input [31:0] a_i,
  input [31:0] b_i,
  output logic done_o = 1'h0,
  output logic [63:0] prod_o = 64'h0
);
  logic [63:0] p;
  logic [3:0] n = 4'h0;
  always @(posedge clk_i) begin
    done_o <= n == 4'h1;
    // result bus is inverted every cycle outside the done pulse
    prod_o <= n == 4'h1 ? p : ~prod_o;
    n <= start_i ? lat_i : n - {3'h0, n != 4'h0};
    if (start_i) p <= {32'h0, a_i} * {32'h0, b_i};
  end
endmodule // cpm_mdu_model

// *** bench/testbench.sv ***
// self-checking bench for the programming-model block
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'h0, rst_i = 1'h1, big_endian_i = 1'h1, go = 1'h0, mul_done_i;
  logic gpr_wr_i = 1'h0, link_wr_i = 1'h0, div_done_i = 1'h0, hi_wr_i = 1'h0, lo_wr_i = 1'h0;
  logic mem_req_i = 1'h0, mem_store_i = 1'h0, scu_rd_i = 1'h0, scu_wr_i = 1'h0;
  logic exc_i = 1'h0, exc_return_instr_i = 1'h0, mem_ok_o, kernel_mode_o, big_endian_o, exc_raise_o;
  logic [2:0] mem_size_i = 3'h0;
  logic [3:0] lat = 4'h1, lane_en_o;
  logic [4:0] rd_a_sel_i = 5'h0, rd_b_sel_i = 5'h0, gpr_wr_sel_i = 5'h0, scu_sel_i = 5'h0;
  logic [4:0] exc_code_i = 5'h0, exc_raise_code_o;
  logic [31:0] gpr_wr_data_i = 32'h0, link_addr_i = 32'h0, hilo_wr_data_i = 32'h0;
  logic [31:0] mem_addr_i = 32'h0, scu_wr_data_i = 32'h0, exc_pc_i = 32'h0;
  logic [31:0] rd_a_data_o, rd_b_data_o, result_high_o, result_low_o, scu_rd_data_o;
  logic [63:0] mdu_result_i, q;
  logic [8:0] tv [8] = '{{3'h0, 2'h0, 4'h8}, {3'h0, 2'h3, 4'h1}, {3'h1, 2'h2, 4'h3},
    {3'h1, 2'h1, 4'h0}, {3'h2, 2'h0, 4'hF}, {3'h2, 2'h2, 4'h0}, {3'h3, 2'h1, 4'h7},
    {3'h4, 2'h1, 4'hC}};
  int miscompares = 0, n_checks = 0;
  cpm_programming_model DUT (.clk_i, .rst_i, .big_endian_i, .rd_a_sel_i, .rd_b_sel_i,
    .rd_a_data_o, .rd_b_data_o, .gpr_wr_i, .gpr_wr_sel_i, .gpr_wr_data_i, .link_wr_i,
    .link_addr_i, .mul_done_i, .div_done_i, .mdu_result_i, .hi_wr_i, .lo_wr_i, .hilo_wr_data_i,
    .result_high_o, .result_low_o, .mem_req_i, .mem_store_i, .mem_size_i, .mem_addr_i,
    .lane_en_o, .mem_ok_o, .scu_rd_i, .scu_wr_i, .scu_sel_i, .scu_wr_data_i, .scu_rd_data_o,
    .exc_i, .exc_code_i, .exc_pc_i, .exc_return_instr_i, .kernel_mode_o, .big_endian_o,
    .exc_raise_o, .exc_raise_code_o);
  cpm_mdu_model mdu (.clk_i, .start_i(go), .lat_i(lat), .a_i(32'h12345678),
    .b_i(32'h00000010), .done_o(mul_done_i), .prod_o(mdu_result_i));
  initial forever #50 clk_i = ~clk_i;
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task mem(input logic [2:0] s, input logic [31:0] a, input logic [3:0] l);
    @(posedge clk_i);
    mem_req_i <= 1'h1;
    mem_size_i <= s;
    mem_addr_i <= a;
    @(posedge clk_i);
    mem_req_i <= 1'h0;
    #1 chk({28'h0, lane_en_o}, {28'h0, l});
  endtask
  // u selects the control unit, else the general registers
  task wr(input logic u, input logic [4:0] s, input logic [31:0] d);
    @(posedge clk_i);
    {scu_wr_i, gpr_wr_i} <= {u, !u};
    {scu_sel_i, gpr_wr_sel_i, scu_wr_data_i, gpr_wr_data_i} <= {s, s, d, d};
    @(posedge clk_i);
    {scu_wr_i, gpr_wr_i} <= 2'h0;
  endtask
  task rd(input logic u, input logic [4:0] s, input logic [31:0] e);
    @(posedge clk_i);
    scu_rd_i <= u;
    {rd_a_sel_i, rd_b_sel_i, scu_sel_i} <= {s, s, s};
    @(posedge clk_i);
    scu_rd_i <= 1'h0;
    #1 chk(u ? scu_rd_data_o : rd_a_data_o, e);
    if (!u) chk(rd_b_data_o, e);
  endtask
  // x high: external exception, low: exception return
  task ev(input logic x);
    @(posedge clk_i);
    {exc_i, exc_return_instr_i, exc_code_i, exc_pc_i} <= {x, !x, 5'h08, 32'h00001234};
    @(posedge clk_i);
    {exc_i, exc_return_instr_i} <= 2'h0;
    #1 chk({31'h0, kernel_mode_o}, {31'h0, x});
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    big_endian_i <= 1'h0;
    @(posedge clk_i);
    #1 chk({31'h0, big_endian_o}, 32'h1);
    wr(1'h0, 5'h05, 32'h89ABCDEF);
    rd(1'h0, 5'h05, 32'h89ABCDEF);
    wr(1'h0, 5'h00, 32'hFFFFFFFF);
    rd(1'h0, 5'h00, 32'h0);
    wr(1'h0, 5'h1F, 32'h00000011);
    rd(1'h0, 5'h1F, 32'h00000011);
    @(posedge clk_i);
    {link_wr_i, link_addr_i} <= {1'h1, 32'h00400008};
    @(posedge clk_i);
    link_wr_i <= 1'h0;
    rd(1'h0, 5'h1F, 32'h00400008);
    $display("register test done");
    for (int i = 0; i < 8; i++) mem(tv[i][8:6], {30'h0, tv[i][5:4]}, tv[i][3:0]);
    $display("lane test done");
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_i);
      {lat, go} <= {j ? 4'h6 : 4'h1, 1'h1};
      @(posedge clk_i);
      go <= 1'h0;
      for (int k = 0; k < 20 && mul_done_i !== 1'h1; k++) @(posedge clk_i) #1;
      @(posedge clk_i);
      #1 chk(result_high_o, 32'h00000001);
      chk(result_low_o, 32'h23456780);
    end
    @(posedge clk_i);
    {hi_wr_i, hilo_wr_data_i} <= {1'h1, 32'h0000C0DE};
    @(posedge clk_i);
    {hi_wr_i, lo_wr_i, hilo_wr_data_i} <= {2'h1, 32'h0000BEEF};
    @(posedge clk_i);
    lo_wr_i <= 1'h0;
    #1 chk(result_high_o, 32'h0000C0DE);
    chk(result_low_o, 32'h0000BEEF);
    @(posedge clk_i);
    {div_done_i, lo_wr_i} <= 2'h3;
    @(posedge clk_i);
    {div_done_i, lo_wr_i} <= 2'h0;
    q = mdu_result_i;
    #1 chk(result_high_o, q[63:32]);
    chk(result_low_o, q[31:0]);
    $display("result pair test done");
    wr(1'h1, 5'h03, 32'h0000005A);
    rd(1'h1, 5'h03, 32'h0000005A);
    rd(1'h1, 5'h09, 32'h0);
    rd(1'h1, 5'h0F, 32'h00000A5A);
    wr(1'h1, 5'h0C, 32'h00000002);
    #1 chk({31'h0, kernel_mode_o}, 32'h0);
    mem_store_i <= 1'h1;
    mem(3'h2, 32'h80000000, 4'h0);
    chk({27'h0, exc_raise_code_o}, 32'h5);
    rd(1'h1, 5'h0C, 32'h00000008);
    rd(1'h1, 5'h08, 32'h80000000);
    rd(1'h1, 5'h0D, 32'h00000014);
    ev(1'h0);
    rd(1'h1, 5'h03, 32'h0);
    chk({27'h0, exc_raise_code_o}, 32'hB);
    ev(1'h0);
    ev(1'h1);
    rd(1'h1, 5'h0E, 32'h00001234);
    $display("mode test done");
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    mem(3'h0, 32'h0, 4'h1);
    mem(3'h1, 32'h2, 4'hC);
    $display("order test done");
    end_of_test;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
endmodule // testbench
